// ### common/dcl_pkg.sv
package dcl_pkg;
   // Register offsets (printed 0x00, 0x01 are indices; byte address is index times four)
   localparam logic [7:0]  CONTROL_IDX       = 8'h00;
   localparam logic [7:0]  CODE_IDX          = 8'h01;
   localparam logic [11:0] CONTROL_ADDR      = 12'h000;
   localparam logic [11:0] CODE_ADDR         = 12'h004;
   localparam logic [11:0] POWER_STATE_ADDR  = 12'h008;
   localparam int          ADDR_W            = 12;
   // Control field positions
   localparam int          ENABLE_BIT        = 0;
   localparam int          PIN_BUF_BIT       = 6;
   localparam int          STANDBY_RUN_BIT   = 7;
   localparam logic [7:0]  CONTROL_WR_MASK   = 8'hc1;
   localparam logic [7:0]  CONTROL_RESET     = 8'h00;
   localparam logic [7:0]  CODE_RESET        = 8'h00;
   // Power state field positions
   localparam int          ST_CORE_ON_BIT    = 0;
   localparam int          ST_BUF_ON_BIT     = 1;
   localparam int          ST_SETTLE_BIT     = 2;
   localparam int          ST_INTERNAL_BIT   = 3;
   localparam int          ST_PIN_BIT        = 4;
   // Start-up time after power-up before a conversion is issued
   localparam int          CLK_PERIOD_NS     = 100;
   localparam int          STARTUP_NS        = 1000;
   localparam int          STARTUP_CYCLES    = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          STARTUP_W         = 8;
   typedef enum logic [1:0] {SLEEP_ACTIVE, SLEEP_IDLE, SLEEP_STANDBY, SLEEP_POWERDOWN} dcl_sleep_t;
endpackage : dcl_pkg

// ### common/dcl_start_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dcl_start_if;
   logic       powered;
   logic       settled;
   logic [7:0] load;
   modport ctrl  (output powered, input settled, output load);
   modport timer (input powered, output settled, input load);
endinterface : dcl_start_if
`default_nettype wire

// ### rtl/dcl_control.sv
// Notes on behaviour
// - Enable bit 0 powers converter on/off
// - Code write while enabled starts conversion
// - Code write while disabled only stores
// - Bit 6 powers buffer, routes to pin
// - Only first instance drives a pin
// - Output offered to internal consumers only while core is powered (not in halted standby or power-down)
// - Bit 7 keeps converting in standby
// - Bit 7 clear halts in standby
// - Halted standby powers core and buffer off
// - Wake re-powers, waits start-up before converting
// - Power-down always powers everything off
// - Full 8-bit code drives converter
// - Debug halt changes nothing
// - Logic runs on peripheral clock
`timescale 1ns/100ps
`default_nettype none
module dcl_control
   import dcl_pkg::*;
#(
   parameter bit IS_FIRST_INSTANCE = 1'b1
)(
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   input  wire logic [3:0]        PSTRB,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic [1:0]        SLEEP_MODE,
   input  wire logic              DEBUG_HALT,
   output logic                   CORE_POWER,
   output logic                   PIN_BUFFER_POWER,
   output logic                   PIN_ROUTE,
   output logic                   INTERNAL_OFFER,
   output logic [7:0]             CONVERT_CODE,
   output logic                   CONVERT_STROBE
);
   logic [7:0]  converter_control;
   logic [7:0]  converter_code;
   logic        pending;
   logic [1:0]  sleep_s1;
   logic [1:0]  sleep_s2;
   logic        debug_s1;
   logic        debug_s2;
   logic        wr_en;
   logic        rd_en;
   logic        hit_ctrl;
   logic        hit_code;
   logic        hit_stat;
   logic        halt_sleep;
   logic        next_core;
   logic        next_buf;
   logic        keep_running_in_standby;
   logic        pin_buffer_on;
   logic        enable;
   dcl_sleep_t  sleep_mode;
   dcl_start_if sif ();

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         sleep_s1 <= 2'h0;
         sleep_s2 <= 2'h0;
         debug_s1 <= 1'b0;
         debug_s2 <= 1'b0;
      end else begin
         sleep_s1 <= SLEEP_MODE;
         sleep_s2 <= sleep_s1;
         debug_s1 <= DEBUG_HALT;
         debug_s2 <= debug_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   // peripheral clock
   assign wr_en    = PSEL && PENABLE && PWRITE && PREADY;
   assign rd_en    = PSEL && !PENABLE && !PWRITE;
   assign hit_ctrl = (PADDR == CONTROL_ADDR);
   assign hit_code = (PADDR == CODE_ADDR);
   assign hit_stat = (PADDR == POWER_STATE_ADDR);
   assign keep_running_in_standby = converter_control[STANDBY_RUN_BIT];
   assign pin_buffer_on           = converter_control[PIN_BUF_BIT];
   assign enable                  = converter_control[ENABLE_BIT];
   assign sleep_mode              = dcl_sleep_t'(sleep_s2);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
      end else begin
         PREADY <= PSEL && !PENABLE;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         PSLVERR <= 1'b0;
      end else begin
         PSLVERR <= PSEL && !PENABLE && !(hit_ctrl || hit_code || (hit_stat && !PWRITE));
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd_en) begin
         if (hit_ctrl) begin
            PRDATA <= {24'h00_0000, converter_control};
         end else if (hit_code) begin
            PRDATA <= {24'h00_0000, converter_code};
         end else if (hit_stat) begin
            PRDATA <= {27'h000_0000, PIN_ROUTE, INTERNAL_OFFER, sif.settled,
                       PIN_BUFFER_POWER, CORE_POWER};
         end else begin
            PRDATA <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   // enable bit write
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         converter_control <= CONTROL_RESET;
      end else if (wr_en && hit_ctrl && PSTRB[0]) begin
         converter_control <= PWDATA[7:0] & CONTROL_WR_MASK;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         converter_code <= CODE_RESET;
      end else if (wr_en && hit_code && PSTRB[0]) begin
         converter_code <= PWDATA[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power control
   // debug halt ignored
   always_comb begin
      case (sleep_mode)
         SLEEP_STANDBY:   halt_sleep = !keep_running_in_standby;
         SLEEP_POWERDOWN: halt_sleep = 1'b1;
         default:         halt_sleep = 1'b0;
      endcase
   end

   assign next_core = enable && !halt_sleep;
   assign next_buf  = next_core && pin_buffer_on && IS_FIRST_INSTANCE;
   assign sif.powered = next_core;
   assign sif.load    = 8'(STARTUP_CYCLES);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         CORE_POWER       <= 1'b0;
         PIN_BUFFER_POWER <= 1'b0;
         PIN_ROUTE        <= 1'b0;
         INTERNAL_OFFER   <= 1'b0;
      end else begin
         CORE_POWER       <= next_core;
         PIN_BUFFER_POWER <= next_buf;
         PIN_ROUTE        <= next_buf;
         INTERNAL_OFFER   <= next_core;
      end
   end

   dcl_startup u_startup (
      .MCLK  (MCLK),
      .RST_N (RST_N),
      .sif   (sif.timer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Conversion start
   // start on write
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         pending <= 1'b0;
      end else if (!next_core) begin
         pending <= 1'b1;
      end else if (sif.settled) begin
         pending <= 1'b0;
      end else if (wr_en && hit_code && PSTRB[0]) begin
         pending <= 1'b1;
      end
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         CONVERT_CODE   <= CODE_RESET;
         CONVERT_STROBE <= 1'b0;
      end else begin
         CONVERT_STROBE <= 1'b0;
         if (sif.settled && (pending || (wr_en && hit_code && PSTRB[0]))) begin
            CONVERT_CODE   <= (wr_en && hit_code && PSTRB[0]) ? PWDATA[7:0] : converter_code;
            CONVERT_STROBE <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_off_when_disabled;
      @(posedge MCLK) disable iff (!RST_N)
      !enable |=> !CORE_POWER;
   endproperty
   a_off_when_disabled: assert property (p_off_when_disabled)
      else $error("Core powered while disabled");

   property p_write_starts;
      @(posedge MCLK) disable iff (!RST_N)
      (wr_en && hit_code && PSTRB[0] && sif.settled && next_core)
         |=> CONVERT_STROBE && CONVERT_CODE == $past(PWDATA[7:0]);
   endproperty
   a_write_starts: assert property (p_write_starts)
      else $error("Code write did not start conversion");

   property p_no_start_disabled;
      @(posedge MCLK) disable iff (!RST_N)
      !CORE_POWER |-> !CONVERT_STROBE;
   endproperty
   a_no_start_disabled: assert property (p_no_start_disabled)
      else $error("Conversion while disabled");

   property p_pin_first;
      @(posedge MCLK) disable iff (!RST_N)
      PIN_ROUTE |-> (IS_FIRST_INSTANCE && CORE_POWER && $past(pin_buffer_on));
   endproperty
   a_pin_first: assert property (p_pin_first)
      else $error("Pin routed illegally");

   property p_internal;
      @(posedge MCLK) disable iff (!RST_N)
      INTERNAL_OFFER == CORE_POWER;
   endproperty
   a_internal: assert property (p_internal)
      else $error("Internal offer mismatch");

   property p_powerdown;
      @(posedge MCLK) disable iff (!RST_N)
      (sleep_mode == SLEEP_POWERDOWN) |=> !CORE_POWER && !PIN_BUFFER_POWER;
   endproperty
   a_powerdown: assert property (p_powerdown)
      else $error("Powered in power-down");

   property p_standby_halt;
      @(posedge MCLK) disable iff (!RST_N)
      (sleep_mode == SLEEP_STANDBY && !keep_running_in_standby) |=> !CORE_POWER;
   endproperty
   a_standby_halt: assert property (p_standby_halt)
      else $error("Powered in halted standby");

   property p_standby_buffer;
      @(posedge MCLK) disable iff (!RST_N)
      (sleep_mode == SLEEP_STANDBY && !keep_running_in_standby) |=> !PIN_BUFFER_POWER;
   endproperty
   a_standby_buffer: assert property (p_standby_buffer)
      else $error("Buffer powered in halted standby");

   property p_wake_convert;
      @(posedge MCLK) disable iff (!RST_N)
      ($rose(sif.settled) && !(wr_en && hit_code && PSTRB[0]))
         |=> CONVERT_STROBE && CONVERT_CODE == $past(converter_code);
   endproperty
   a_wake_convert: assert property (p_wake_convert)
      else $error("Stored code not converted after start-up");

   property p_startup_wait;
      @(posedge MCLK) disable iff (!RST_N)
      $rose(CORE_POWER) |-> !CONVERT_STROBE [*2];
   endproperty
   a_startup_wait: assert property (p_startup_wait)
      else $error("Conversion before start-up");

   property p_code_hold;
      @(posedge MCLK) disable iff (!RST_N)
      !CONVERT_STROBE |-> $stable(CONVERT_CODE);
   endproperty
   a_code_hold: assert property (p_code_hold)
      else $error("Code changed without conversion");

   c_convert: cover property (@(posedge MCLK) disable iff (!RST_N) CONVERT_STROBE);
   c_pin:     cover property (@(posedge MCLK) disable iff (!RST_N) PIN_ROUTE);
   c_wake:    cover property (@(posedge MCLK) disable iff (!RST_N) $rose(CORE_POWER));
   c_debug:   cover property (@(posedge MCLK) disable iff (!RST_N) debug_s2 && CORE_POWER);
endmodule : dcl_control
`default_nettype wire

// ### rtl/dcl_startup.sv
`timescale 1ns/100ps
`default_nettype none
module dcl_startup
   import dcl_pkg::*;
(
   input  wire logic  MCLK,
   input  wire logic  RST_N,
   dcl_start_if.timer sif
);
   logic [STARTUP_W-1:0] count;
   logic                 powered_q;

   // Counts start-up cycles after each power-up
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         count     <= '0;
         powered_q <= 1'b0;
      end else begin
         powered_q <= sif.powered;
         if (!sif.powered) begin
            count <= '0;
         end else if (!powered_q) begin
            count <= sif.load;
         end else if (count != '0) begin
            count <= count - 1'b1;
         end
      end
   end

   assign sif.settled = sif.powered && powered_q && (count == '0);
endmodule : dcl_startup
`default_nettype wire

// ### tb/dcl_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcl_core_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       core_power,
   input  wire logic [7:0] convert_code,
   input  wire logic       convert_strobe,
   output logic [7:0]      held_code,
   output int              conv_count
);
   ////////////////////////////////////////////////////////////////
   // latch code, count conversions
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         held_code <= 8'h00;
         conv_count <= 0;
      end else if (convert_strobe && core_power) begin
         held_code <= convert_code;
         conv_count <= conv_count + 1;
      end
   end
endmodule : dcl_core_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import dcl_pkg::*;
   logic mclk, rst_n, psel, penable, pwrite, dbg;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, rv;
   logic [3:0] pstrb;
   logic [1:0] sleep;
   logic pready, pslverr, core, buf_on, route, offer, strobe, e;
   logic buf2, route2, offer2;
   logic [7:0] code, held, c;
   int cnt, fail_count, n_tests, cyc;
   dcl_control dcl_control_inst (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .SLEEP_MODE(sleep), .DEBUG_HALT(dbg),
      .CORE_POWER(core), .PIN_BUFFER_POWER(buf_on), .PIN_ROUTE(route),
      .INTERNAL_OFFER(offer), .CONVERT_CODE(code), .CONVERT_STROBE(strobe));
   dcl_core_model dcl_core_model_inst (.mclk(mclk), .rst_n(rst_n), .core_power(core),
      .convert_code(code), .convert_strobe(strobe), .held_code(held), .conv_count(cnt));
   // Second instance without a pin driver, on the same bus
   dcl_control #(.IS_FIRST_INSTANCE(1'b0)) dcl_control_inst_other (.MCLK(mclk),
      .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(), .PREADY(), .PSLVERR(),
      .SLEEP_MODE(sleep), .DEBUG_HALT(dbg), .CORE_POWER(), .PIN_BUFFER_POWER(buf2),
      .PIN_ROUTE(route2), .INTERNAL_OFFER(offer2), .CONVERT_CODE(), .CONVERT_STROBE());
   function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
      return {24'h00_0000, v[7:0] & CONTROL_WR_MASK};
   endfunction : ctrl_exp
   ////////////////////////////////////////////////////////////////
   // peripheral clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic complete_run();
      if (fail_count == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      n_tests++;
      if (s !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   task automatic wpow(input logic v);
      repeat (40) begin
         @(posedge mclk);
         if (core === v) break;
      end
   endtask : wpow
   task automatic wconv(input int n);
      repeat (40) begin
         @(posedge mclk);
         if (cnt >= n) break;
      end
      chk("conversions", cnt, n);
   endtask : wconv
   initial begin
      {psel, penable, pwrite, dbg} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
      sleep = SLEEP_ACTIVE;
      rst_n = 1'b0;
      void'($urandom(2180));
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk("reset core", core, 1'b0);
      apb(CONTROL_ADDR, 1'b0, 32'h0);
      chk("control reset", r, 32'h0);
      chk("read error", e, 1'b0);
      apb(CODE_ADDR, 1'b0, 32'h0);
      chk("code reset", r, 32'h0);
      c = 8'($urandom);
      apb(CODE_ADDR, 1'b1, {24'h0, c});
      repeat (20) @(posedge mclk);
      chk("no start", cnt, 0);
      apb(CONTROL_ADDR, 1'b1, 32'h1);
      wpow(1'b1);
      chk("core on", core, 1'b1);
      chk("offer", offer, 1'b1);
      chk("route off", route, 1'b0);
      wconv(1);
      chk("held", held, c);
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? 8'hff : 8'($urandom);
         apb(CODE_ADDR, 1'b1, {24'h0, c});
         wconv(cnt + 1);
         chk("held code", held, c);
      end
      apb(CONTROL_ADDR, 1'b1, 32'hffffffff);
      apb(CONTROL_ADDR, 1'b0, 32'h0);
      chk("control mask", r, ctrl_exp(32'hffffffff));
      repeat (4) @(posedge mclk);
      chk("buffer", buf_on, 1'b1);
      chk("pin route", route, 1'b1);
      chk("other buffer", buf2, 1'b0);
      chk("other route", route2, 1'b0);
      chk("other offer", offer2, 1'b1);
      sleep <= SLEEP_STANDBY;
      dbg <= 1'b1;
      repeat (10) @(posedge mclk);
      chk("standby run", core, 1'b1);
      c = 8'($urandom);
      apb(CODE_ADDR, 1'b1, {24'h0, c});
      wconv(cnt + 1);
      chk("debug code", held, c);
      dbg <= 1'b0;
      sleep <= SLEEP_POWERDOWN;
      wpow(1'b0);
      chk("pd core", core, 1'b0);
      chk("pd buffer", buf_on, 1'b0);
      sleep <= SLEEP_ACTIVE;
      wpow(1'b1);
      wconv(cnt + 1);
      apb(CONTROL_ADDR, 1'b1, 32'h41);
      sleep <= SLEEP_STANDBY;
      wpow(1'b0);
      chk("sb core", core, 1'b0);
      chk("sb buffer", buf_on, 1'b0);
      sleep <= SLEEP_ACTIVE;
      wpow(1'b1);
      repeat (2) @(posedge mclk);
      chk("wake buffer", buf_on, 1'b1);
      wconv(cnt + 1);
      chk("held wake", held, c);
      pstrb <= 4'he;
      apb(CODE_ADDR, 1'b1, {24'h0, ~c});
      pstrb <= 4'hf;
      apb(CODE_ADDR, 1'b0, 32'h0);
      chk("lane ignored", r, {24'h0, c});
      apb(POWER_STATE_ADDR, 1'b0, 32'h0);
      chk("status", r, 32'h1f);
      chk("status error", e, 1'b0);
      apb(CONTROL_ADDR, 1'b1, 32'h0);
      wpow(1'b0);
      chk("core off", core, 1'b0);
      for (int i = 0; i < 4; i++) begin
         rv = $urandom & 32'hffff_fffe;
         apb(CONTROL_ADDR, 1'b1, rv);
         apb(CONTROL_ADDR, 1'b0, 32'h0);
         chk("control random", r, ctrl_exp(rv));
         chk("core stays off", core, 1'b0);
      end
      apb(POWER_STATE_ADDR, 1'b1, 32'h1);
      chk("ro refused", e, 1'b1);
      apb(12'h00c, 1'b0, 32'h0);
      chk("unmapped", e, 1'b1);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
